// ===== bench/csb_partner.sv
`timescale 1ns/10ps
module csb_partner (
    input  wire        pclk,
    input  wire        lock_n_i,
    input  wire        want_bus,
    output logic       priority_bus_request_n,
    output logic       owns_bus,
    output logic       power_ok_in,
    output logic [2:0] response_status_n
);
    initial begin
        priority_bus_request_n = 1'b1;
        owns_bus = 1'b0;
        response_status_n = 3'h7;
        power_ok_in = 1'b0;
        @(posedge pclk);
        power_ok_in <= 1'b1;
    end
    always @(posedge pclk) begin
        priority_bus_request_n <= !want_bus;
        owns_bus <= want_bus && !priority_bus_request_n && lock_n_i;
        response_status_n <= want_bus ? 3'h5 : 3'h7;
    end
endmodule

// ===== bench/csb_sideband_checker.sv
`timescale 1ns/10ps
module csb_sideband_checker (
    input wire       pclk,
    input wire       presetn,
    input wire [1:0] local_irq_pins,
    input wire       local_irq_event,
    input wire       maskable_irq_request,
    input wire       nmi_request,
    input wire       init_n,
    input wire       built_in_self_test,
    input wire       cache_invalidate,
    input wire       sensor_hot,
    input wire       thermal_alarm_n_o,
    input wire       thermal_alarm_n_oe,
    input wire       lock_n_o,
    input wire       lock_n_oe,
    input wire       req_cmd_n_oe,
    input wire       probe_request_n,
    input wire       probe_ready_n,
    input wire       bus_reset_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_excl; !(maskable_irq_request && local_irq_event); endproperty
    a_excl: assert property (p_excl) else $error("irq overlap");
    property p_quiet; (local_irq_pins == 2'h0)[*8] |-> !(local_irq_event || maskable_irq_request || nmi_request); endproperty
    a_quiet: assert property (p_quiet) else $error("irq stuck");
    property p_rel; $fell(bus_reset_n) |-> ##[1:8] !(lock_n_oe || req_cmd_n_oe); endproperty
    a_rel: assert property (p_rel) else $error("bus not released");
    property p_hot; sensor_hot[*3] |-> thermal_alarm_n_oe; endproperty
    a_hot: assert property (p_hot) else $error("alarm not driven");
    property p_lvl; !((lock_n_oe && lock_n_o) || (thermal_alarm_n_oe && thermal_alarm_n_o)); endproperty
    a_lvl: assert property (p_lvl) else $error("pin driven high");
    property p_probe; probe_request_n[*3] |-> probe_ready_n; endproperty
    a_probe: assert property (p_probe) else $error("probe ready unasked");
    property p_inv; $rose(presetn) |-> cache_invalidate ##1 !cache_invalidate; endproperty
    a_inv: assert property (p_inv) else $error("invalidate pulse");
    property p_built_in_self_test; $rose(presetn) |-> ##8 (built_in_self_test == !init_n); endproperty
    a_built_in_self_test: assert property (p_built_in_self_test) else $error("self test");
    c_lock: cover property (lock_n_oe);
    c_nmi: cover property (nmi_request);
    c_mir: cover property (maskable_irq_request);
endmodule

bind csb_sideband csb_sideband_checker u_chk (.*);

// ===== bench/csb_sideband_tb_top.sv
`timescale 1ns/10ps
`include "csb_defines.vh"
module csb_sideband_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, init_n, sensor_hot, alarm_ext_n;
    logic        local_irq_event, maskable_irq_request, nmi_request, built_in_self_test, cache_invalidate;
    logic        thermal_alarm_n_i, thermal_alarm_n_o, thermal_alarm_n_oe, thermal_control_circuit, lock_n_i;
    logic        lock_n_o, lock_n_oe, priority_bus_request_n, probe_request_n, probe_ready_n, power_ok_in;
    logic        power_status_indicator_n, req_cmd_n_oe, address_strobe0_n, bus_reset_n, want_bus, owns_bus;
    logic [1:0]  local_irq_pins;
    logic [2:0]  response_status_n, irq_v;
    logic [4:0]  req_cmd_n_i, req_cmd_n_o;
    logic [7:0]  strap_pins;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int          bad_count, comparisons, m;

    csb_sideband uut (.*);
    csb_partner u_far (.*);
    assign thermal_alarm_n_i = thermal_alarm_n_oe ? thermal_alarm_n_o : alarm_ext_n;
    assign lock_n_i = lock_n_oe ? lock_n_o : 1'b1;
    assign req_cmd_n_i = req_cmd_n_oe ? req_cmd_n_o : 5'h1F;
    assign irq_v = {local_irq_event, maskable_irq_request, nmi_request};

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 16) begin
            bad_count++;
            stop_test();
        end
    endtask

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, sensor_hot, want_bus, init_n, local_irq_pins, paddr, pwdata} = '0;
        {probe_request_n, bus_reset_n, alarm_ext_n, address_strobe0_n} = '1;
        strap_pins = 8'hA5;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `CSB_OFF_CTRL, 0);
        chk("ctrl", rd, 32'h03);
        chk("bist1", built_in_self_test, 1'b1);
        apb(0, `CSB_OFF_STRAPS, 0);
        chk("straps", rd, 32'hA5);
        apb(0, 12'hFFC, 0);
        chk("unmapped", rd, 32'h0);
        @(posedge pclk);
        local_irq_pins <= 2'h1;
        wt(8);
        chk("irq", irq_v, 3'h4);
        apb(1, `CSB_OFF_CTRL, 32'h02);
        wt(8);
        chk("maskable_irq_request", irq_v, 3'h2);
        @(posedge pclk);
        local_irq_pins <= 2'h2;
        sensor_hot <= 1'b1;
        wt(8);
        chk("nmi", irq_v, 3'h1);
        chk("hot", {thermal_alarm_n_oe, thermal_control_circuit}, 2'h3);
        @(posedge pclk);
        sensor_hot <= 1'b0;
        alarm_ext_n <= 1'b0;
        wt(8);
        chk("ext_off", thermal_control_circuit, 1'b0);
        apb(1, `CSB_OFF_CTRL, 32'h06);
        wt(8);
        chk("ext_on", thermal_control_circuit, 1'b1);
        @(posedge pclk);
        alarm_ext_n <= 1'b1;
        probe_request_n <= 1'b0;
        wt(8);
        chk("ext_rel", thermal_control_circuit, 1'b0);
        $display("irq and thermal done");
        for (m = 0; m < 4; m++) begin
            apb(1, `CSB_OFF_CTRL, 32'h0A | (m << 5));
            wt(3);
            chk("psi", power_status_indicator_n, m == 3);
            chk("probe_ready_n", probe_ready_n, 1'b0);
        end
        $display("probe and power done");
        apb(1, `CSB_OFF_LOCK, 32'h1);
        apb(1, `CSB_OFF_REQCMD, 32'h10B);
        @(posedge pclk);
        want_bus <= 1'b1;
        probe_request_n <= 1'b1;
        wt(6);
        chk("lock", {lock_n_oe, owns_bus, req_cmd_n_oe, req_cmd_n_o}, 8'hB4);
        @(posedge pclk);
        address_strobe0_n <= 1'b0;
        wt(6);
        apb(0, `CSB_OFF_REQCMD, 0);
        chk("reqcmd", rd, 32'h0001_0B0B);
        @(posedge pclk);
        bus_reset_n <= 1'b0;
        wt(8);
        chk("bus_rst", {lock_n_oe, req_cmd_n_oe}, 2'h0);
        @(posedge pclk);
        bus_reset_n <= 1'b1;
        apb(1, `CSB_OFF_LOCK, 32'h0);
        wt(6);
        chk("unlock", owns_bus, 1'b1);
        $display("lock and bus reset done");
        @(posedge pclk);
        presetn <= 1'b0;
        init_n <= 1'b1;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        wt(10);
        chk("built_in_self_test", built_in_self_test, 1'b0);
        apb(0, `CSB_OFF_CTRL, 0);
        chk("ctrl2", rd, 32'h03);
        $display("second reset done");
        stop_test();
    end
endmodule

// ===== src/csb_defines.vh
`ifndef CSB_DEFINES_VH
`define CSB_DEFINES_VH

// Register byte offsets
`define CSB_OFF_CTRL        12'h000
`define CSB_OFF_STATUS      12'h004
`define CSB_OFF_LOCK        12'h008
`define CSB_OFF_REQCMD      12'h00C
`define CSB_OFF_STRAPS      12'h010

// Control register fields
`define CSB_CTRL_LIC_EN     0
`define CSB_CTRL_TCC_EN     1
`define CSB_CTRL_BIDIR      2
`define CSB_CTRL_PROBE_RDY  3
`define CSB_CTRL_HOT        4
`define CSB_CTRL_PMODE_LO   5
`define CSB_CTRL_PMODE_HI   6

// Control reset value: controller enabled, thermal circuit enabled, output-only pin
`define CSB_CTRL_RESET      7'h03

// Power modes
`define CSB_PM_HFM          2'h0
`define CSB_PM_LFM          2'h1
`define CSB_PM_DEEP_SLEEP   2'h2
`define CSB_PM_OTHER        2'h3

// Timing
`define CSB_CLK_PERIOD_NS   10
`define CSB_RELEASE_CLKS    2
`define CSB_ECHO_CLKS       3'h5
`define CSB_STRAP_W         8

`endif

// ===== src/csb_sideband.v
// Contract
// RQ1: controller off: pin0 maskable, pin1 nonmaskable
// RQ2: interrupt pins accepted asynchronously, synchronised
// RQ3: controller enabled after reset
// RQ4: lock held across whole locked sequence
// RQ5: priority agent waits for lock release
// RQ6: probe request in, probe ready out
// RQ7: sensor hot drives thermal alarm active
// RQ8: bidirectional mode: external alarm activates circuit
// RQ9: externally activated circuit holds until release
// RQ10: alarm pin output only by default
// RQ11: power status follows operating mode
// RQ12: power-good held low clean, rises monotonic
// RQ13: power-good high during boundary scan
// RQ14: bus owner drives five request lines
// RQ15: reset clears state, invalidates cache, no writeback
// RQ16: power-on reset held two milliseconds
// RQ17: outputs released within two clocks of reset; code takes five clocks after bus_reset_n falls
// RQ18: straps valid before reset release, latched
// RQ19: response status lines input only
// RQ20: asynchronous inputs pass multi-stage synchroniser
// RQ21: init active at reset release runs self-test
`timescale 1ns/10ps
`include "csb_defines.vh"

module csb_sideband (
    input  wire        pclk,
    input  wire        presetn,
    input  wire [11:0] paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire [1:0]  local_irq_pins,
    output wire        local_irq_event,
    output wire        maskable_irq_request,
    output wire        nmi_request,
    input  wire        init_n,
    output wire        built_in_self_test,
    output wire        cache_invalidate,
    input  wire [7:0]  strap_pins,
    input  wire        sensor_hot,
    input  wire        thermal_alarm_n_i,
    output wire        thermal_alarm_n_o,
    output wire        thermal_alarm_n_oe,
    output wire        thermal_control_circuit,
    input  wire        lock_n_i,
    output wire        lock_n_o,
    output wire        lock_n_oe,
    input  wire        priority_bus_request_n,
    input  wire        probe_request_n,
    output wire        probe_ready_n,
    output wire        power_status_indicator_n,
    input  wire        power_ok_in,
    input  wire [4:0]  req_cmd_n_i,
    output wire [4:0]  req_cmd_n_o,
    output wire        req_cmd_n_oe,
    input  wire        address_strobe0_n,
    input  wire [2:0]  response_status_n,
    input  wire        bus_reset_n
);

    //--------------------------------------------------------------
    // Input synchronisers
    //--------------------------------------------------------------
    localparam NSYNC = 7;
    wire [NSYNC-1:0] async_in;
    wire [NSYNC-1:0] sync_out;
    assign async_in = {bus_reset_n, init_n, address_strobe0_n, power_ok_in,
                       thermal_alarm_n_i, local_irq_pins};

    // Chains run through reset so that init and idle levels are
    // already settled at release; no false edge after reset
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            reg s1_q;
            reg s2_q;
            reg s3_q;
            reg st_q;
            always @(posedge pclk) begin // RQ2 RQ20
                s1_q <= async_in[gi];
                s2_q <= s1_q;
                s3_q <= s2_q;
                if (s2_q == s3_q) begin
                    st_q <= s3_q;
                end
            end
            assign sync_out[gi] = st_q;
        end
    endgenerate

    wire [1:0] lint_s      = sync_out[1:0];
    wire       alarm_in_s  = ~sync_out[2];
    wire       pwr_ok_s    = sync_out[3];
    wire       adstb_s     = sync_out[4];
    wire       init_act_s  = ~sync_out[5];
    wire       bus_rst_s   = ~sync_out[6];

    //--------------------------------------------------------------
    // Registers
    //--------------------------------------------------------------
    reg [6:0]  ctrl_q;
    reg        lock_req_q;
    reg [4:0]  req_cmd_q;
    reg        req_drive_q;
    reg [7:0]  strap_q;
    reg        strap_taken_q;
    reg        built_in_self_test_q;
    reg        inval_q;
    reg [1:0]  rst_cnt_q;
    reg        released_q;
    reg        adstb_q;
    reg [4:0]  req_seen_q;

    wire mapped = (paddr == `CSB_OFF_CTRL) || (paddr == `CSB_OFF_STATUS) ||
                  (paddr == `CSB_OFF_LOCK) || (paddr == `CSB_OFF_REQCMD) ||
                  (paddr == `CSB_OFF_STRAPS);
    wire wr_en = psel & penable & pwrite & mapped;
    wire rd_en = psel & ~penable & ~pwrite;

    // Bus answer and pin levels held in flops
    reg pready_q;
    reg pslverr_q;
    reg pin_low_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b1;
            pslverr_q <= 1'b0;
            pin_low_q <= 1'b0;
        end else begin
            pready_q  <= 1'b1;
            pslverr_q <= 1'b0;
            pin_low_q <= 1'b0;
        end
    end

    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q      <= `CSB_CTRL_RESET; // RQ3 RQ10
            lock_req_q  <= 1'b0;
            req_cmd_q   <= 5'h00;
            req_drive_q <= 1'b0;
        end else if (bus_rst_s) begin
            ctrl_q      <= `CSB_CTRL_RESET; // RQ15
            lock_req_q  <= 1'b0;
            req_drive_q <= 1'b0;
        end else if (wr_en) begin
            case (paddr)
                `CSB_OFF_CTRL:   ctrl_q <= pwdata[6:0];
                `CSB_OFF_LOCK:   lock_req_q <= pwdata[0]; // RQ4
                `CSB_OFF_REQCMD: begin
                    req_cmd_q   <= pwdata[4:0]; // RQ14
                    req_drive_q <= pwdata[8];
                end
                default: ;
            endcase
        end
    end

    // Reset release counting, strap latch, self-test and cache invalidate
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cnt_q     <= 2'h0;
            released_q    <= 1'b0;
            strap_q       <= 8'h00;
            strap_taken_q <= 1'b0;
            built_in_self_test_q        <= 1'b0;
            inval_q       <= 1'b1;
        end else if (bus_rst_s) begin
            rst_cnt_q     <= 2'h0;
            released_q    <= 1'b0;
            strap_taken_q <= 1'b0;
            built_in_self_test_q        <= 1'b0;
            inval_q       <= 1'b1; // RQ15
        end else begin
            inval_q <= 1'b0;
            if (!strap_taken_q) begin
                strap_q       <= strap_pins; // RQ18
                strap_taken_q <= 1'b1;
                built_in_self_test_q        <= init_act_s; // RQ21
            end
            if (rst_cnt_q != `CSB_RELEASE_CLKS)
                rst_cnt_q <= rst_cnt_q + 2'h1;
            else
                released_q <= 1'b1;
        end
    end

    // Request lines sampled on address strobe edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adstb_q    <= 1'b1;
            req_seen_q <= 5'h1F;
        end else begin
            adstb_q <= adstb_s;
            if (adstb_q && !adstb_s)
                req_seen_q <= req_cmd_n_i; // RQ14
        end
    end

    //--------------------------------------------------------------
    // Sideband outputs
    //--------------------------------------------------------------
    reg lint_evt_q;
    reg maskable_irq_request_q;
    reg nmi_q;
    reg tcc_q;
    reg ext_hot_q;
    reg alarm_drv_q;
    reg probe_ready_n_n_q;
    reg psi_n_q;
    reg lock_drv_q;
    reg req_oe_q;
    reg [4:0] req_o_q;
    reg [2:0] echo_cnt_q;

    wire lic_en   = ctrl_q[`CSB_CTRL_LIC_EN];
    wire tcc_en   = ctrl_q[`CSB_CTRL_TCC_EN];
    wire bidir    = ctrl_q[`CSB_CTRL_BIDIR];
    wire hot      = sensor_hot | ctrl_q[`CSB_CTRL_HOT];
    wire [1:0] pm = ctrl_q[`CSB_CTRL_PMODE_HI:`CSB_CTRL_PMODE_LO];
    wire ext_hot  = bidir & alarm_in_s & ~alarm_drv_q & (echo_cnt_q == 3'h0); // RQ10
    wire bus_ok   = ~bus_rst_s & released_q & pwr_ok_s;

    //--------------------------------------------------------------
    // Local interrupt pins
    //--------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lint_evt_q <= 1'b0;
            maskable_irq_request_q     <= 1'b0;
            nmi_q      <= 1'b0;
        end else begin
            lint_evt_q <= lic_en & (|lint_s);
            maskable_irq_request_q     <= ~lic_en & lint_s[0]; // RQ1
            nmi_q      <= ~lic_en & lint_s[1]; // RQ1
        end
    end

    //--------------------------------------------------------------
    // Thermal alarm and control circuit
    //--------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tcc_q       <= 1'b0;
            ext_hot_q   <= 1'b0;
            alarm_drv_q <= 1'b0;
            echo_cnt_q  <= 3'h0;
        end else begin
            alarm_drv_q <= hot & bus_ok; // RQ7
            // Own drive still echoes through the sync chain after release
            if (alarm_drv_q) begin
                echo_cnt_q <= `CSB_ECHO_CLKS;
            end else if (echo_cnt_q != 3'h0) begin
                echo_cnt_q <= echo_cnt_q - 3'h1;
            end
            // Set wins over release in the same cycle
            if (ext_hot) begin
                ext_hot_q <= 1'b1; // RQ8
            end else if (!alarm_in_s || !bidir) begin
                ext_hot_q <= 1'b0; // RQ9
            end
            tcc_q <= tcc_en & (hot | ext_hot | (ext_hot_q & alarm_in_s));
        end
    end

    //--------------------------------------------------------------
    // Probe handshake and power status
    //--------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            probe_ready_n_n_q <= 1'b1;
            psi_n_q  <= 1'b1;
        end else begin
            probe_ready_n_n_q <= ~(~probe_request_n & ctrl_q[`CSB_CTRL_PROBE_RDY]); // RQ6
            psi_n_q  <= ~((pm == `CSB_PM_HFM) | (pm == `CSB_PM_LFM) |
                          (pm == `CSB_PM_DEEP_SLEEP)); // RQ11
        end
    end

    //--------------------------------------------------------------
    // Bus drive
    //--------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_drv_q <= 1'b0;
            req_oe_q   <= 1'b0;
            req_o_q    <= 5'h1F;
        end else begin
            lock_drv_q <= lock_req_q & bus_ok; // RQ4 RQ17
            req_oe_q   <= req_drive_q & bus_ok; // RQ17
            req_o_q    <= ~req_cmd_q;
        end
    end

    assign local_irq_event          = lint_evt_q;
    assign maskable_irq_request     = maskable_irq_request_q;
    assign nmi_request              = nmi_q;
    assign built_in_self_test       = built_in_self_test_q;
    assign cache_invalidate         = inval_q;
    assign thermal_alarm_n_o        = pin_low_q;
    assign thermal_alarm_n_oe       = alarm_drv_q;
    assign thermal_control_circuit  = tcc_q;
    assign lock_n_o                 = pin_low_q;
    assign lock_n_oe                = lock_drv_q;
    assign probe_ready_n            = probe_ready_n_n_q;
    assign power_status_indicator_n = psi_n_q;
    assign req_cmd_n_o              = req_o_q;
    assign req_cmd_n_oe             = req_oe_q;

    //--------------------------------------------------------------
    // Read data
    //--------------------------------------------------------------
    reg [31:0] rdata_d;

    always @* begin
        rdata_d = 32'h0000_0000;
        case (paddr)
            `CSB_OFF_CTRL:   rdata_d = {25'h0, ctrl_q};
            `CSB_OFF_STATUS: rdata_d = {21'h0, response_status_n, ~priority_bus_request_n,
                                        ~lock_n_i, pwr_ok_s, built_in_self_test_q, tcc_q,
                                        alarm_in_s, lint_s}; // RQ19 RQ5
            `CSB_OFF_LOCK:   rdata_d = {31'h0, lock_req_q};
            `CSB_OFF_REQCMD: rdata_d = {15'h0, req_drive_q, 3'h0, ~req_seen_q, 3'h0, req_cmd_q};
            `CSB_OFF_STRAPS: rdata_d = {24'h0, strap_q};
            default:         rdata_d = 32'h0000_0000;
        endcase
    end

    // Read data captured in the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata <= rdata_d;
        end
    end

endmodule
